// file: hdl/mult_pkg.sv
/*
 * Constants and types for the word multiply unit: register byte
 * offsets, control and status field positions, reset values and the
 * operation encoding.
 * Assumes a 32-bit APB slave with byte addresses; each register holds
 * one aligned word with its narrower data in the low bits.
 */
package mult_pkg;

    // bus and word geometry
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 32;
    localparam int unsigned WORD_W = 16;
    localparam int unsigned RES_WORDS = 4;

    // register byte offsets
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] STATUS_OFS = 8'h04;
    localparam logic [7:0] MCAND_LO_OFS = 8'h08;
    localparam logic [7:0] MCAND_HI_OFS = 8'h0C;
    localparam logic [7:0] MPLIER_LO_OFS = 8'h10;
    localparam logic [7:0] MPLIER_HI_OFS = 8'h14;
    localparam logic [7:0] RES0_OFS = 8'h18;
    localparam logic [7:0] RES1_OFS = 8'h1C;
    localparam logic [7:0] RES2_OFS = 8'h20;
    localparam logic [7:0] RES3_OFS = 8'h24;

    // control fields
    localparam int unsigned CTRL_COND_BIT = 0;
    localparam int unsigned CTRL_EDGE_BIT = 1;
    localparam int unsigned CTRL_OP_LSB = 2;

    // status fields
    localparam int unsigned STAT_FAULT_BIT = 0;
    localparam int unsigned STAT_ZERO_BIT = 1;
    localparam int unsigned STAT_TOP_BIT = 2;
    localparam int unsigned STAT_DONE_BIT = 3;

    // reset values
    localparam logic [15:0] WORD_RST = 16'h0000;
    localparam logic [31:0] DATA_RST = 32'h00000000;

    // a 16-digit product of two 8-digit decimals stays below 2**54
    localparam int unsigned BCD_PROD_BITS = 54;

    // multiply operations
    typedef enum logic [1:0] {
        BIN_SINGLE,
        BIN_DOUBLE,
        BCD_SINGLE,
        BCD_DOUBLE
    } mult_op_type;

endpackage : mult_pkg

// file: hdl/bcd_to_bin.sv
/*
 * Packed BCD to binary converter with a per-digit validity check.
 * Purely combinational; assumes the caller registers what it needs.
 */
`timescale 1ns/1ps

module bcd_to_bin #(
    parameter int unsigned DIGITS = 8
) (
    input wire logic [4*DIGITS-1:0] bcd_i, // packed digits, low digit at bit 0
    output logic [31:0] bin_o,             // binary value of the digits
    output logic bad_o                     // some nibble above nine
);

    // accumulate digits from the top, times ten each step
    always_comb begin
        logic [31:0] acc;
        logic bad;
        acc = 32'h00000000;
        bad = 1'b0;
        for (int d = DIGITS - 1; d >= 0; d--) begin
            if (bcd_i[4*d +: 4] > 4'h9) begin
                bad = 1'b1;
            end
            acc = (acc << 3) + (acc << 1) + {28'h0000000, bcd_i[4*d +: 4]};
        end
        bin_o = acc;
        bad_o = bad;
    end

endmodule : bcd_to_bin

// file: hdl/word_multiply_unit.sv
/*
 * Word multiply unit: unsigned binary and packed BCD multiplies on
 * single or double words, with fault, zero and top-bit flags, reached
 * over an APB slave.
 * Assumes one 100 MHz clock, asynchronous active-high reset, and a
 * sequencer that loads operands and raises the execution condition.
 */
// Decided for this implementation: the register offsets and the APB slave port.

// How it works
// - single binary multiplies the two low 16-bit words into a 32-bit product in two words.
// - both binary multiplies always clear the fault flag.
// - every run but a faulted BCD one sets the zero flag exactly when the whole product is zero.
// - single binary copies product bit 31 into the top-bit flag.
// - double binary copies product bit 63 into the top-bit flag.
// - double binary multiplies two 32-bit word pairs into a 64-bit product in four words.
// - single BCD multiplies two four-digit operands into an eight-digit product in two words.
// - single BCD raises the fault flag when either low word holds a non-decimal nibble.
// - double BCD multiplies two eight-digit operands into a sixteen-digit product in four words.
// - an operation runs each cycle the condition is true, or once on its rising edge.
// - double BCD raises the fault flag when any of the four operand words is not decimal.
`timescale 1ns/1ps

module word_multiply_unit (
    input wire logic clk_i,                               // 100 MHz clock
    input wire logic sys_rst_i,                           // async reset, high
    input wire logic psel_i,                              // apb select
    input wire logic penable_i,                           // apb access phase
    input wire logic pwrite_i,                            // apb write
    input wire logic [mult_pkg::ADDR_W-1:0] paddr_i,      // apb byte address
    input wire logic [mult_pkg::DATA_W-1:0] pwdata_i,     // apb write data
    output logic [mult_pkg::DATA_W-1:0] prdata_o,         // apb read data
    output logic pready_o,                                // apb ready
    output logic pslverr_o,                               // apb error
    output logic fault_flag_o,                            // operand fault
    output logic zero_flag_o,                             // product zero
    output logic top_flag_o                               // product top bit
);

    // control and operand state
    logic cond_r, cond_nxt;
    logic edge_mode_r, edge_mode_nxt;
    logic [1:0] op_r, op_nxt;
    logic cond_prev_r, cond_prev_nxt;
    logic [15:0] mcand_lo_r, mcand_lo_nxt;
    logic [15:0] mcand_hi_r, mcand_hi_nxt;
    logic [15:0] mplier_lo_r, mplier_lo_nxt;
    logic [15:0] mplier_hi_r, mplier_hi_nxt;

    // results and flags
    logic [15:0] res_r [mult_pkg::RES_WORDS];
    logic [15:0] res_nxt [mult_pkg::RES_WORDS];
    logic fault_r, fault_nxt;
    logic zero_r, zero_nxt;
    logic top_r, top_nxt;
    logic done_r, done_nxt;

    // bus answer state
    logic [31:0] prdata_r, prdata_nxt;
    logic pready_r, pready_nxt;
    logic pslverr_r, pslverr_nxt;

    // decode and datapath wires
    logic setup_ph;
    logic wr_en;
    logic mapped;
    logic [31:0] rdata;
    logic exec_go;
    logic single_op;
    mult_pkg::mult_op_type op_sel;
    logic [31:0] opnd_a;
    logic [31:0] opnd_b;
    logic [31:0] bcd_a_bin;
    logic [31:0] bcd_b_bin;
    logic bcd_a_bad;
    logic bcd_b_bad;
    logic [63:0] bin_prod;
    logic [63:0] bcd_prod_bin;
    logic [63:0] prod;

    // double dabble of the binary product into sixteen digits
    function automatic logic [63:0] bin_to_bcd(input logic [63:0] bin);
        logic [63:0] bcd;
        bcd = 64'h0000000000000000;
        for (int i = mult_pkg::BCD_PROD_BITS - 1; i >= 0; i--) begin
            for (int d = 0; d < 16; d++) begin
                if (bcd[4*d +: 4] > 4'h4) begin
                    bcd[4*d +: 4] = bcd[4*d +: 4] + 4'h3;
                end
            end
            bcd = {bcd[62:0], bin[i]};
        end
        return bcd;
    endfunction : bin_to_bcd

    // apb phase decode
    assign setup_ph = psel_i & ~penable_i;
    assign wr_en = psel_i & penable_i & pwrite_i & pready_r;

    // operation select and operand assembly, low word at the base
    assign op_sel = mult_pkg::mult_op_type'(op_r);
    assign single_op = (op_sel == mult_pkg::BIN_SINGLE) || (op_sel == mult_pkg::BCD_SINGLE);
    assign opnd_a = single_op ? {16'h0000, mcand_lo_r} : {mcand_hi_r, mcand_lo_r};
    assign opnd_b = single_op ? {16'h0000, mplier_lo_r} : {mplier_hi_r, mplier_lo_r};

    // a cleared high word also keeps the single check to the low word
    bcd_to_bin #(
        .DIGITS(8)
    ) u_cand_conv (
        .bcd_i(opnd_a),
        .bin_o(bcd_a_bin),
        .bad_o(bcd_a_bad)
    );

    bcd_to_bin #(
        .DIGITS(8)
    ) u_plier_conv (
        .bcd_i(opnd_b),
        .bin_o(bcd_b_bin),
        .bad_o(bcd_b_bad)
    );

    // binary and decimal products
    assign bin_prod = {32'h00000000, opnd_a} * {32'h00000000, opnd_b};
    assign bcd_prod_bin = {32'h00000000, bcd_a_bin} * {32'h00000000, bcd_b_bin};

    always_comb begin
        if ((op_sel == mult_pkg::BCD_SINGLE) || (op_sel == mult_pkg::BCD_DOUBLE)) begin
            prod = bin_to_bcd(bcd_prod_bin);
        end else begin
            prod = bin_prod;
        end
    end

    // execution trigger: level each cycle, or only on a rising edge
    assign exec_go = cond_r & (~edge_mode_r | ~cond_prev_r);
    assign cond_prev_nxt = cond_r;

    // read mux and address map
    always_comb begin
        rdata = mult_pkg::DATA_RST;
        mapped = 1'b1;
        unique case (paddr_i)
            mult_pkg::CTRL_OFS: begin
                rdata[mult_pkg::CTRL_COND_BIT] = cond_r;
                rdata[mult_pkg::CTRL_EDGE_BIT] = edge_mode_r;
                rdata[mult_pkg::CTRL_OP_LSB +: 2] = op_r;
            end
            mult_pkg::STATUS_OFS: begin
                rdata[mult_pkg::STAT_FAULT_BIT] = fault_r;
                rdata[mult_pkg::STAT_ZERO_BIT] = zero_r;
                rdata[mult_pkg::STAT_TOP_BIT] = top_r;
                rdata[mult_pkg::STAT_DONE_BIT] = done_r;
            end
            mult_pkg::MCAND_LO_OFS: rdata[15:0] = mcand_lo_r;
            mult_pkg::MCAND_HI_OFS: rdata[15:0] = mcand_hi_r;
            mult_pkg::MPLIER_LO_OFS: rdata[15:0] = mplier_lo_r;
            mult_pkg::MPLIER_HI_OFS: rdata[15:0] = mplier_hi_r;
            mult_pkg::RES0_OFS: rdata[15:0] = res_r[0];
            mult_pkg::RES1_OFS: rdata[15:0] = res_r[1];
            mult_pkg::RES2_OFS: rdata[15:0] = res_r[2];
            mult_pkg::RES3_OFS: rdata[15:0] = res_r[3];
            default: mapped = 1'b0;
        endcase
    end

    // apb answer: ready in the first access cycle, error when unmapped
    always_comb begin
        pready_nxt = setup_ph;
        pslverr_nxt = setup_ph & ~mapped;
        prdata_nxt = (setup_ph & ~pwrite_i) ? rdata : mult_pkg::DATA_RST;
    end

    // software writes to control and operand words
    always_comb begin
        cond_nxt = cond_r;
        edge_mode_nxt = edge_mode_r;
        op_nxt = op_r;
        mcand_lo_nxt = mcand_lo_r;
        mcand_hi_nxt = mcand_hi_r;
        mplier_lo_nxt = mplier_lo_r;
        mplier_hi_nxt = mplier_hi_r;
        if (wr_en) begin
            unique case (paddr_i)
                mult_pkg::CTRL_OFS: begin
                    cond_nxt = pwdata_i[mult_pkg::CTRL_COND_BIT];
                    edge_mode_nxt = pwdata_i[mult_pkg::CTRL_EDGE_BIT];
                    op_nxt = pwdata_i[mult_pkg::CTRL_OP_LSB +: 2];
                end
                mult_pkg::MCAND_LO_OFS: mcand_lo_nxt = pwdata_i[15:0];
                mult_pkg::MCAND_HI_OFS: mcand_hi_nxt = pwdata_i[15:0];
                mult_pkg::MPLIER_LO_OFS: mplier_lo_nxt = pwdata_i[15:0];
                mult_pkg::MPLIER_HI_OFS: mplier_hi_nxt = pwdata_i[15:0];
                default: begin
                end
            endcase
        end
    end

    // execution: results and flags
    always_comb begin
        for (int w = 0; w < mult_pkg::RES_WORDS; w++) begin
            res_nxt[w] = res_r[w];
        end
        fault_nxt = fault_r;
        zero_nxt = zero_r;
        top_nxt = top_r;
        done_nxt = done_r;
        // software clears done by writing one; an execution in the same cycle wins
        if (wr_en && (paddr_i == mult_pkg::STATUS_OFS) && pwdata_i[mult_pkg::STAT_DONE_BIT]) begin
            done_nxt = 1'b0;
        end
        if (exec_go) begin
            done_nxt = 1'b1;
            unique case (op_sel)
                mult_pkg::BIN_SINGLE: begin
                    res_nxt[0] = prod[15:0];
                    res_nxt[1] = prod[31:16];
                    fault_nxt = 1'b0;
                    zero_nxt = (prod[31:0] == 32'h00000000);
                    top_nxt = prod[31];
                end
                mult_pkg::BIN_DOUBLE: begin
                    for (int w = 0; w < mult_pkg::RES_WORDS; w++) begin
                        res_nxt[w] = prod[16*w +: 16];
                    end
                    fault_nxt = 1'b0;
                    zero_nxt = (prod == 64'h0000000000000000);
                    top_nxt = prod[63];
                end
                mult_pkg::BCD_SINGLE: begin
                    fault_nxt = bcd_a_bad | bcd_b_bad;
                    if (!(bcd_a_bad | bcd_b_bad)) begin
                        res_nxt[0] = prod[15:0];
                        res_nxt[1] = prod[31:16];
                        zero_nxt = (prod[31:0] == 32'h00000000);
                    end
                end
                mult_pkg::BCD_DOUBLE: begin
                    fault_nxt = bcd_a_bad | bcd_b_bad;
                    if (!(bcd_a_bad | bcd_b_bad)) begin
                        for (int w = 0; w < mult_pkg::RES_WORDS; w++) begin
                            res_nxt[w] = prod[16*w +: 16];
                        end
                        zero_nxt = (prod == 64'h0000000000000000);
                    end
                end
            endcase
        end
    end

    // register everything
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            cond_r <= 1'b0;
            edge_mode_r <= 1'b0;
            op_r <= 2'h0;
            cond_prev_r <= 1'b0;
            mcand_lo_r <= mult_pkg::WORD_RST;
            mcand_hi_r <= mult_pkg::WORD_RST;
            mplier_lo_r <= mult_pkg::WORD_RST;
            mplier_hi_r <= mult_pkg::WORD_RST;
            for (int w = 0; w < mult_pkg::RES_WORDS; w++) begin
                res_r[w] <= mult_pkg::WORD_RST;
            end
            fault_r <= 1'b0;
            zero_r <= 1'b0;
            top_r <= 1'b0;
            done_r <= 1'b0;
            prdata_r <= mult_pkg::DATA_RST;
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
        end else begin
            cond_r <= cond_nxt;
            edge_mode_r <= edge_mode_nxt;
            op_r <= op_nxt;
            cond_prev_r <= cond_prev_nxt;
            mcand_lo_r <= mcand_lo_nxt;
            mcand_hi_r <= mcand_hi_nxt;
            mplier_lo_r <= mplier_lo_nxt;
            mplier_hi_r <= mplier_hi_nxt;
            for (int w = 0; w < mult_pkg::RES_WORDS; w++) begin
                res_r[w] <= res_nxt[w];
            end
            fault_r <= fault_nxt;
            zero_r <= zero_nxt;
            top_r <= top_nxt;
            done_r <= done_nxt;
            prdata_r <= prdata_nxt;
            pready_r <= pready_nxt;
            pslverr_r <= pslverr_nxt;
        end
    end

    // outputs straight from flops
    assign prdata_o = prdata_r;
    assign pready_o = pready_r;
    assign pslverr_o = pslverr_r;
    assign fault_flag_o = fault_r;
    assign zero_flag_o = zero_r;
    assign top_flag_o = top_r;

endmodule : word_multiply_unit

// file: test/word_multiply_unit_chk.sv
/* port checker for the word multiply unit
   assumes it is bound onto word_multiply_unit */
`timescale 1ns/1ps
module word_multiply_unit_chk (
    input wire logic clk_i, // clock
    input wire logic sys_rst_i, // reset
    input wire logic psel_i, // select
    input wire logic penable_i, // access
    input wire logic pwrite_i, // write
    input wire logic [mult_pkg::ADDR_W-1:0] paddr_i, // address
    input wire logic [mult_pkg::DATA_W-1:0] pwdata_i, // write data
    input wire logic [mult_pkg::DATA_W-1:0] prdata_o, // read data
    input wire logic pready_o, // ready
    input wire logic pslverr_o, // error
    input wire logic fault_flag_o, // fault
    input wire logic zero_flag_o, // zero
    input wire logic top_flag_o // top bit
);
    logic in_map;
    logic setup;
    logic rd_ok;
    // address decode and phase detect
    assign in_map = paddr_i <= 8'h24 && paddr_i[1:0] == 2'h0;
    assign setup = psel_i && !penable_i;
    assign rd_ok = pready_o && !pwrite_i;
    default clocking @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);
    chk_ready_delay: assert property (setup |=> pready_o)
        else $error("no ready after setup");
    chk_ready_access: assert property (pready_o |-> psel_i && penable_i)
        else $error("ready outside access");
    chk_err_ready: assert property (pslverr_o |-> pready_o)
        else $error("error without ready");
    chk_rdata_idle: assert property (!pready_o |-> prdata_o == 32'h0)
        else $error("read data not idle");
    chk_unmapped_err: assert property (setup && !in_map |=> pslverr_o)
        else $error("unmapped without error");
    chk_mapped_ok: assert property (setup && in_map |=> !pslverr_o)
        else $error("mapped with error");
    chk_status_mirror: assert property (
        rd_ok && paddr_i == mult_pkg::STATUS_OFS |-> prdata_o[0] == $past(fault_flag_o)
        && prdata_o[1] == $past(zero_flag_o) && prdata_o[2] == $past(top_flag_o))
        else $error("status differs from flags");
    chk_res_upper: assert property (
        rd_ok && in_map && paddr_i >= mult_pkg::RES0_OFS |-> prdata_o[31:16] == 16'h0)
        else $error("result upper bits set");
endmodule : word_multiply_unit_chk

bind word_multiply_unit word_multiply_unit_chk chk_u (.clk_i, .sys_rst_i, .psel_i,
    .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o,
    .fault_flag_o, .zero_flag_o, .top_flag_o);

// file: test/apb_seq_model.sv
/* sequencer model: apb master issuing one transfer at a time
   assumes a slave that ends each access with pready */
`timescale 1ns/1ps
module apb_seq_model (
    input wire logic clk_i, // clock
    output logic psel_o, // select
    output logic penable_o, // access
    output logic pwrite_o, // write
    output logic [7:0] paddr_o, // address
    output logic [31:0] pwdata_o, // write data
    input wire logic [31:0] prdata_i, // read data
    input wire logic pready_i, // ready
    input wire logic pslverr_i // error
);
    // idle bus at time zero
    initial begin
        psel_o = 1'b0;
        penable_o = 1'b0;
        pwrite_o = 1'b0;
        paddr_o = 8'h00;
        pwdata_o = 32'h0;
    end
    // one transfer, held until ready, then released with stale lines scrambled
    task xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
              output logic [31:0] q, output logic e);
        @(posedge clk_i);
        psel_o <= 1'b1;
        pwrite_o <= w;
        paddr_o <= a;
        pwdata_o <= d;
        @(posedge clk_i);
        penable_o <= 1'b1;
        // wait as long as it takes; only the bench watchdog ends a hang
        do begin
            @(posedge clk_i);
        end while (!pready_i);
        q = prdata_i;
        e = pslverr_i;
        psel_o <= 1'b0;
        penable_o <= 1'b0;
        paddr_o <= ~a;
        pwdata_o <= ~d;
    endtask : xfer
endmodule : apb_seq_model

// file: test/tb_word_multiply_unit.sv
/* self-checking bench for the word multiply unit
   assumes the sequencer model drives the register bus */
`timescale 1ns/1ps
module tb_word_multiply_unit;
    logic clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic psel, penable, pwrite, pready, pslverr, fault, zero, top, e;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, q;
    int n_mismatch = 0;
    int checks_done = 0;
    // 100 MHz clock
    always #5 clk_i = ~clk_i;
    apb_seq_model seq_u (.clk_i, .psel_o(psel), .penable_o(penable), .pwrite_o(pwrite),
        .paddr_o(paddr), .pwdata_o(pwdata), .prdata_i(prdata), .pready_i(pready),
        .pslverr_i(pslverr));
    word_multiply_unit dut_u (.clk_i, .sys_rst_i, .psel_i(psel), .penable_i(penable),
        .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
        .pready_o(pready), .pslverr_o(pslverr), .fault_flag_o(fault),
        .zero_flag_o(zero), .top_flag_o(top));
    task cmp(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : cmp
    task wr(input logic [7:0] a, input logic [31:0] d);
        seq_u.xfer(1'b1, a, d, q, e);
    endtask : wr
    task rd(input logic [7:0] a, input logic [31:0] exp, input logic err);
        seq_u.xfer(1'b0, a, 32'h0, q, e);
        cmp(q, exp);
        cmp({31'h0, e}, {31'h0, err});
    endtask : rd
    // load operands low word first, run level mode briefly, drop condition
    task run(input mult_pkg::mult_op_type op, input logic [31:0] a, input logic [31:0] b);
        wr(mult_pkg::MCAND_LO_OFS, {16'h0, a[15:0]});
        wr(mult_pkg::MCAND_HI_OFS, {16'h0, a[31:16]});
        wr(mult_pkg::MPLIER_LO_OFS, {16'h0, b[15:0]});
        wr(mult_pkg::MPLIER_HI_OFS, {16'h0, b[31:16]});
        wr(mult_pkg::CTRL_OFS, {28'h0, op, 2'b01});
        repeat (3) @(posedge clk_i);
        wr(mult_pkg::CTRL_OFS, {28'h0, op, 2'b00});
    endtask : run
    // result words, status with done set, and flag pins
    task chk_out(input logic [63:0] p, input int words, input logic [2:0] f);
        for (int i = 0; i < words; i++) begin
            rd(mult_pkg::RES0_OFS + 8'(4 * i), {16'h0, p[16*i +: 16]}, 1'b0);
        end
        rd(mult_pkg::STATUS_OFS, {28'h0, 1'b1, f}, 1'b0);
        cmp({29'h0, top, zero, fault}, {29'h0, f});
    endtask : chk_out
    // one edge or level run, then clear done and see if it comes back
    task mode_chk(input logic edge_m, input logic [31:0] st);
        wr(mult_pkg::CTRL_OFS, {28'h0, mult_pkg::BCD_DOUBLE, edge_m, 1'b1});
        repeat (3) @(posedge clk_i);
        rd(mult_pkg::STATUS_OFS, st | 32'h8, 1'b0);
        wr(mult_pkg::STATUS_OFS, 32'h8);
        repeat (3) @(posedge clk_i);
        rd(mult_pkg::STATUS_OFS, st, 1'b0);
        wr(mult_pkg::CTRL_OFS, 32'h0);
    endtask : mode_chk
    task t_reset_map;
        rd(mult_pkg::CTRL_OFS, 32'h0, 1'b0);
        rd(mult_pkg::STATUS_OFS, 32'h0, 1'b0);
        rd(8'h28, 32'h0, 1'b1);
        rd(8'h06, 32'h0, 1'b1);
    endtask : t_reset_map
    task t_binary;
        run(mult_pkg::BIN_SINGLE, 32'hFFFF, 32'hFFFF);
        chk_out(64'hFFFE0001, 2, 3'b100);
        run(mult_pkg::BIN_SINGLE, 32'h1234, 32'h0);
        chk_out(64'h0, 2, 3'b010);
        run(mult_pkg::BIN_DOUBLE, 32'hFFFFFFFF, 32'hFFFFFFFF);
        chk_out(64'hFFFFFFFE00000001, 4, 3'b100);
    endtask : t_binary
    task t_decimal;
        run(mult_pkg::BCD_SINGLE, 32'h9999, 32'h9999);
        chk_out(64'h99980001, 2, 3'b100);
        run(mult_pkg::BCD_SINGLE, 32'h12A4, 32'h2);
        chk_out(64'h99980001, 2, 3'b101);
        run(mult_pkg::BCD_DOUBLE, 32'h99999999, 32'h99999999);
        chk_out(64'h9999999800000001, 4, 3'b100);
        run(mult_pkg::BCD_DOUBLE, 32'h5, 32'h1A000001);
        chk_out(64'h9999999800000001, 4, 3'b101);
        run(mult_pkg::BIN_DOUBLE, 32'h00010000, 32'h00010000);
        chk_out(64'h0000000100000000, 4, 3'b000);
        run(mult_pkg::BCD_DOUBLE, 32'h0, 32'h12345678);
        chk_out(64'h0, 4, 3'b010);
    endtask : t_decimal
    task t_modes;
        mode_chk(1'b1, 32'h2);
        mode_chk(1'b0, 32'hA);
    endtask : t_modes
    task end_sim;
        $display("checks_done %0d n_mismatch %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : end_sim
    // main sequence
    initial begin
        repeat (5) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        t_reset_map;
        t_binary;
        t_decimal;
        t_modes;
        end_sim;
    end
    // watchdog
    initial begin
        repeat (4000) @(posedge clk_i);
        n_mismatch++;
        end_sim;
    end
endmodule : tb_word_multiply_unit
